// ---- src/srsr_defines.svh ----
`ifndef SRSR_DEFINES_SVH
`define SRSR_DEFINES_SVH

// reset cause register bit positions
`define SRSR_CAUSE_POR 7
`define SRSR_CAUSE_EXT 6
`define SRSR_CAUSE_WDT 5
`define SRSR_CAUSE_SMR 4
`define SRSR_CAUSE_RST 8'h00

// least external pulse width, in system clocks
`define SRSR_PIN_MIN_LOW 4

// hold counts, in system clocks
`define SRSR_POR_CYC 256
`define SRSR_POR_XTAL_CYC 5000
`define SRSR_SMR_CYC 66
`define SRSR_SMR_XTAL_CYC 5000

// reset vector location in program memory
`define SRSR_VEC_HI_ADDR 16'h0002
`define SRSR_VEC_LO_ADDR 16'h0003

`endif

// ---- src/srsr_pin_filter.sv ----
`include "srsr_defines.svh"
`default_nettype none

module srsr_pin_filter #(
	parameter int MIN_LOW = `SRSR_PIN_MIN_LOW
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pin_in,
	input wire logic mask,
	output logic pin_high,
	output logic pin_hit
);
	localparam int CNTW = $clog2(MIN_LOW + 1);
	localparam logic [CNTW-1:0] LAST = CNTW'(MIN_LOW - 1);

	logic sync1;
	logic sync2;
	logic [CNTW-1:0] low_cnt;
	wire low_now = ~sync2 & ~mask;

	// two stages before anything looks at the pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
		end
	end

	// shorter runs of low samples restart the count and never hit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
		end else if (!low_now) begin
			low_cnt <= '0;
		end else if (low_cnt != LAST) begin
			low_cnt <= low_cnt + 1'b1;
		end
	end

	assign pin_high = sync2;
	assign pin_hit = low_now & (low_cnt == LAST);

	property p_hit_width;
		@(posedge ref_clk) disable iff (!rst_n)
		pin_hit |-> !sync2 && !$past(sync2) && !$past(sync2, 2) && !$past(sync2, 3);
	endproperty
	a_hit_width: assert property (p_hit_width) else $error("hit on short low pulse");

	property p_long_hits;
		@(posedge ref_clk) disable iff (!rst_n)
		(!mask && !sync2) [*4] |-> pin_hit;
	endproperty
	a_long_hits: assert property (p_long_hits) else $error("long low pulse missed");

endmodule : srsr_pin_filter

`default_nettype wire

// ---- src/srsr_pkg.sv ----
`default_nettype none

package srsr_pkg;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_RELEASE,
		ST_RUN,
		ST_STOP,
		ST_SMR,
		ST_VEC_HI,
		ST_VEC_LO,
		ST_VEC_LD
	} srsr_state_t;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_POR,
		SRC_EXT,
		SRC_WDT
	} srsr_src_t;

endpackage : srsr_pkg

`default_nettype wire

// ---- src/srsr_top.sv ----
// Functional notes
// - ignore pin pulses under four clocks, except in stop mode
// - stay reset while pin low, exit after
// - external reset sets external flag
// - power-on delay, longer with crystal (release of rst_n always loads the crystal count, whatever xtal_en is)
// - power-on sets flag, then vector fetch
// - watchdog resets only in reset mode
// - drive pin low in reset delay, not release
// - internal event pulls pin until delay
// - debug request bit resets the system
// - debug bit self-clears, sets power-on flag
// - stop instruction enters stop mode
// - stop recovery holds cpu 66/5000 cycles
// - stop recovery leaves other registers alone
// - stop recovery selects internal oscillator
// - load pc from 0002h and 0003h
`include "srsr_defines.svh"
`default_nettype none

module srsr_top
	import srsr_pkg::*;
#(
	parameter int POR_CYC = `SRSR_POR_CYC,
	parameter int POR_XTAL_CYC = `SRSR_POR_XTAL_CYC,
	parameter int SMR_CYC = `SRSR_SMR_CYC,
	parameter int SMR_XTAL_CYC = `SRSR_SMR_XTAL_CYC,
	parameter int CW = 13
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic supply_ok,
	input wire logic xtal_en,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic port_rst_out_en,
	input wire logic wdt_timeout,
	input wire logic wdt_reset_mode,
	input wire logic dbg_ctl_wr,
	input wire logic [7:0] dbg_ctl_wdata,
	output logic dbg_rst_req,
	input wire logic debug_pin_line_n,
	input wire logic stop_exec,
	input wire logic stop_wake,
	input wire logic cause_clr,
	output logic [7:0] reset_cause_register,
	output logic sys_rst,
	output logic cpu_rst,
	output logic stop_mode,
	output logic osc_sel_int_rc,
	output logic pmem_rd_en,
	output logic [15:0] pmem_addr,
	input wire logic [7:0] pmem_rdata,
	output logic pc_load,
	output logic [15:0] pc_value
);
	function automatic logic is_sys_rst(input srsr_state_t st);
		is_sys_rst = (st == ST_RESET) || (st == ST_RELEASE);
	endfunction : is_sys_rst

	srsr_state_t state;
	srsr_state_t next_state;
	srsr_src_t src;
	logic [CW-1:0] cnt;
	logic [7:0] vec_hi;
	logic pin_high;
	logic pin_hit;

	srsr_pin_filter u_filter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_in(reset_pin_in),
		.mask(port_rst_out_en),
		.pin_high(pin_high),
		.pin_hit(pin_hit)
	);

	wire stop_st = (state == ST_STOP);
	wire active = !is_sys_rst(state) && !stop_st;
	wire wdt_rst = wdt_timeout & wdt_reset_mode;
	// in stop the clock-based filter cannot run, so any low sample counts
	wire pin_ext = active ? pin_hit : (stop_st & ~pin_high);
	wire go_rst = ~supply_ok | (active & (dbg_rst_req | wdt_rst)) | pin_ext
		| (stop_st & ~debug_pin_line_n);
	wire srsr_src_t go_src = (~supply_ok | (active & dbg_rst_req)) ? SRC_POR :
		pin_ext ? SRC_EXT : (active & wdt_rst) ? SRC_WDT : SRC_NONE;
	wire [CW-1:0] lim_por = xtal_en ? CW'(POR_XTAL_CYC - 1) : CW'(POR_CYC - 1);
	wire [CW-1:0] lim_smr = xtal_en ? CW'(SMR_XTAL_CYC - 1) : CW'(SMR_CYC - 1);
	wire cnt_done = (cnt == '0);
	wire smr_enter = stop_st & stop_wake & ~go_rst;
	wire rst_done = (state == ST_RESET) & (next_state == ST_RELEASE);
	wire [7:0] done_flags = (src == SRC_POR) ? 8'(1) << `SRSR_CAUSE_POR :
		(src == SRC_EXT) ? 8'(1) << `SRSR_CAUSE_EXT :
		(src == SRC_WDT) ? 8'(1) << `SRSR_CAUSE_WDT : `SRSR_CAUSE_RST;

	always_comb begin
		next_state = state;
		if (go_rst) begin
			next_state = ST_RESET;
		end else begin
			case (state)
				ST_RESET: if (cnt_done) next_state = ST_RELEASE;
				ST_RELEASE: if (pin_high) next_state = ST_VEC_HI;
				ST_RUN: if (stop_exec) next_state = ST_STOP;
				ST_STOP: if (stop_wake) next_state = ST_SMR;
				ST_SMR: if (cnt_done) next_state = ST_VEC_HI;
				ST_VEC_HI: next_state = ST_VEC_LO;
				ST_VEC_LO: next_state = ST_VEC_LD;
				ST_VEC_LD: next_state = ST_RUN;
				default: next_state = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RESET;
			src <= SRC_POR;
		end else begin
			state <= next_state;
			if (go_rst) src <= go_src;
		end
	end

	// supply dips reload the delay, so it runs from the last valid edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= CW'(POR_XTAL_CYC - 1);
		end else if (go_rst) begin
			cnt <= lim_por;
		end else if (smr_enter) begin
			cnt <= lim_smr;
		end else if (!cnt_done && (state == ST_RESET || state == ST_SMR)) begin
			cnt <= cnt - 1'b1;
		end
	end

	// hardware updates win over a software clear in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_cause_register <= `SRSR_CAUSE_RST;
		end else if (rst_done) begin
			reset_cause_register <= done_flags;
		end else if (smr_enter) begin
			reset_cause_register <= 8'(1) << `SRSR_CAUSE_SMR;
		end else if (cause_clr) begin
			reset_cause_register <= `SRSR_CAUSE_RST;
		end
	end

	// a debugger write beats the reset-state clear; set in the last reset cycle, it requests one more reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dbg_rst_req <= 1'b0;
		end else if (dbg_ctl_wr) begin
			dbg_rst_req <= dbg_ctl_wdata[0];
		end else if (state == ST_RESET) begin
			dbg_rst_req <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_sel_int_rc <= 1'b0;
			vec_hi <= 8'h00;
			pc_value <= 16'h0000;
			pc_load <= 1'b0;
		end else begin
			osc_sel_int_rc <= smr_enter;
			pc_load <= (state == ST_VEC_LD) & ~go_rst;
			if (state == ST_VEC_LO) vec_hi <= pmem_rdata;
			if (state == ST_VEC_LD) pc_value <= {vec_hi, pmem_rdata};
		end
	end

	// the pin is released before the exit check, so our own drive cannot hold reset
	assign reset_pin_oe = (state == ST_RESET) | port_rst_out_en;
	assign reset_pin_out = 1'b0;
	assign sys_rst = is_sys_rst(state);
	// stop recovery only holds the cpu; peripheral registers keep their state
	assign cpu_rst = sys_rst | (state == ST_SMR) | (state == ST_VEC_HI)
		| (state == ST_VEC_LO) | (state == ST_VEC_LD);
	assign stop_mode = stop_st;
	assign pmem_rd_en = (state == ST_VEC_HI) | (state == ST_VEC_LO);
	assign pmem_addr = (state == ST_VEC_LO) ? `SRSR_VEC_LO_ADDR : `SRSR_VEC_HI_ADDR;

	// helper: cycles spent in the current hold
	logic [CW-1:0] hcnt;
	logic harmed;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hcnt <= '0;
			harmed <= 1'b0;
		end else if (go_rst || smr_enter) begin
			hcnt <= '0;
			harmed <= 1'b1;
		end else begin
			hcnt <= hcnt + 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_pin_rst;
		active && supply_ok && pin_hit
			|=> state == ST_RESET && (src == SRC_EXT || $past(dbg_rst_req));
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("filtered pin did not reset");

	property p_release_wait;
		state == ST_RELEASE && supply_ok && !pin_high |=> state == ST_RELEASE && !reset_pin_oe
			|| port_rst_out_en;
	endproperty
	a_release_wait: assert property (p_release_wait) else $error("left reset with pin low");

	property p_ext_flag;
		rst_done && src == SRC_EXT |=> reset_cause_register[`SRSR_CAUSE_EXT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag not set");

	property p_por_len;
		harmed && rst_done && !$past(go_rst)
			|-> hcnt == (xtal_en ? CW'(POR_XTAL_CYC - 1) : CW'(POR_CYC - 1));
	endproperty
	a_por_len: assert property (p_por_len) else $error("power-on delay length wrong");

	property p_por_flag;
		rst_done && src == SRC_POR |=> reset_cause_register[`SRSR_CAUSE_POR] && sys_rst;
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

	property p_wdt;
		active && wdt_timeout && supply_ok |=> (state == ST_RESET) == wdt_reset_mode
			|| $past(pin_hit) || $past(dbg_rst_req);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset mode ignored");

	property p_pin_drive;
		state == ST_RESET |-> reset_pin_oe && !reset_pin_out;
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin not driven in reset");

	property p_dbg_clr;
		state == ST_RESET && !dbg_ctl_wr |=> !dbg_rst_req;
	endproperty
	a_dbg_clr: assert property (p_dbg_clr) else $error("debug request not cleared");

	property p_stop;
		state == ST_RUN && stop_exec && !go_rst |=> stop_mode && !cpu_rst;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not entered");

	property p_smr_len;
		state == ST_SMR && cnt_done
			|-> hcnt == (xtal_en ? CW'(SMR_XTAL_CYC - 1) : CW'(SMR_CYC - 1)) && cpu_rst;
	endproperty
	a_smr_len: assert property (p_smr_len) else $error("stop recovery hold wrong");

	property p_smr_osc;
		smr_enter |=> osc_sel_int_rc && reset_cause_register[`SRSR_CAUSE_SMR] && !sys_rst;
	endproperty
	a_smr_osc: assert property (p_smr_osc) else $error("recovery clock select missing");

	sequence s_fetch_hi;
		state == ST_VEC_HI && pmem_rd_en && pmem_addr == `SRSR_VEC_HI_ADDR;
	endsequence
	sequence s_fetch_lo;
		pmem_rd_en && pmem_addr == `SRSR_VEC_LO_ADDR;
	endsequence
	property p_vector;
		s_fetch_hi ##1 s_fetch_lo ##1 state == ST_VEC_LD && !go_rst |=> pc_load
			&& pc_value == {$past(pmem_rdata, 2), $past(pmem_rdata)};
	endproperty
	a_vector: assert property (p_vector) else $error("reset vector load wrong");

endmodule : srsr_top

`default_nettype wire

// ---- test/srsr_board.sv ----
`default_nettype none

module srsr_board (
	input wire logic ref_clk,
	input wire logic ext_low,
	input wire logic pin_oe,
	output logic pin_lvl,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [15:0] vec,
	output logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// pulled up; whichever side pulls low wins
	logic [7:0] bus_q = 8'h5a;
	assign pin_lvl = !(pin_oe || ext_low);
	assign rdata = bus_q;
	// idle cycles flip the bus so stale bytes never pass for data
	always @(posedge ref_clk) begin
		if (rd_en && addr == 16'h0002)
			bus_q <= vec[15:8];
		else if (rd_en && addr == 16'h0003)
			bus_q <= vec[7:0];
		else
			bus_q <= ~bus_q;
	end
endmodule : srsr_board

`default_nettype wire

// ---- test/tb_srsr_top.sv ----
`default_nettype none

module tb_srsr_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PC = 8, PX = 20, SC = 6, SX = 12;
	logic ref_clk = 0, rst_n = 0, supply_ok = 1, xtal_en = 0, ext_low = 0, p_en = 0;
	logic wdt_to = 0, wdt_mode = 0, dbg_wr = 0, stop_x = 0, wake = 0, clr = 0, dpin_n = 1;
	logic pin_lvl, pin_oe, pin_out, dbg_req, sys_rst, cpu_rst, stop_m, osc, rd_en, pcl;
	logic [7:0] dbg_d = 8'h00, rdata, cause;
	logic [15:0] addr, pcv, vec = 16'h1234;
	int num_errors = 0, num_checks = 0, seed = 32'h344a6cbb, rc, cc, oc, ec, w, n;

	srsr_top #(.POR_CYC(PC), .POR_XTAL_CYC(PX), .SMR_CYC(SC), .SMR_XTAL_CYC(SX)) srsr_top_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .supply_ok(supply_ok), .xtal_en(xtal_en),
		.reset_pin_in(pin_lvl), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
		.port_rst_out_en(p_en), .wdt_timeout(wdt_to), .wdt_reset_mode(wdt_mode),
		.dbg_ctl_wr(dbg_wr), .dbg_ctl_wdata(dbg_d), .dbg_rst_req(dbg_req),
		.debug_pin_line_n(dpin_n), .stop_exec(stop_x), .stop_wake(wake), .cause_clr(clr),
		.reset_cause_register(cause), .sys_rst(sys_rst), .cpu_rst(cpu_rst),
		.stop_mode(stop_m), .osc_sel_int_rc(osc), .pmem_rd_en(rd_en), .pmem_addr(addr),
		.pmem_rdata(rdata), .pc_load(pcl), .pc_value(pcv));
	srsr_board srsr_board_i (.ref_clk(ref_clk), .ext_low(ext_low), .pin_oe(pin_oe),
		.pin_lvl(pin_lvl), .rd_en(rd_en), .addr(addr), .vec(vec), .rdata(rdata));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task complete_run;
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task rng(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : rng

	task tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : tick

	// power-on hold length for the crystal option
	function automatic int hold_len(input logic x);
		return x ? PX : PC;
	endfunction : hold_len

	// counts reset, hold, oscillator and pin cycles until the pc load or lim
	task run_to(input int lim);
		rc = 0;
		cc = 0;
		oc = 0;
		ec = 0;
		vec <= 16'($random(seed));
		for (int i = 0; i < lim && pcl !== 1'b1; i++) begin
			@(posedge ref_clk);
			chk(16'($isunknown({sys_rst, cpu_rst, osc, pin_oe})), 16'h0000);
			rc += int'(sys_rst);
			cc += int'(cpu_rst);
			oc += int'(osc);
			ec += int'(pin_oe);
		end
	endtask : run_to

	task fin(input logic [7:0] exp_cause);
		chk({15'h0000, pcl}, 16'h0001);
		chk(pcv, vec);
		chk({8'h00, cause}, {8'h00, exp_cause});
	endtask : fin

	initial begin
		#400000;
		num_errors++;
		complete_run;
	end

	initial begin
		tick(20);
		rst_n <= 1'b1;
		run_to(600);
		fin(8'h80);
		for (int x = 0; x < 2; x++) begin
			xtal_en <= x[0];
			n = hold_len(x[0]);
			supply_ok <= 1'b0;
			tick(1);
			supply_ok <= 1'b1;
			run_to(600);
			rng(ec, n, n + 2);
			rng(rc, n, n + 6);
			fin(8'h80);
		end
		xtal_en <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			w = i < 3 ? i + 1 : 1 + $unsigned($random(seed)) % 3;
			@(posedge ref_clk) ext_low <= 1'b1;
			tick(w);
			ext_low <= 1'b0;
			run_to(12);
			rng(rc, 0, 0);
		end
		ext_low <= 1'b1;
		tick(4);
		ext_low <= 1'b0;
		run_to(600);
		fin(8'h40);
		ext_low <= 1'b1;
		tick(PC + 30);
		chk({15'h0000, sys_rst}, 16'h0001);
		ext_low <= 1'b0;
		run_to(600);
		rng(rc, 0, 5);
		fin(8'h40);
		p_en <= 1'b1;
		tick(2);
		chk({15'h0000, pin_oe}, 16'h0001);
		chk({15'h0000, pin_out}, 16'h0000);
		tick(6);
		p_en <= 1'b0;
		run_to(12);
		rng(rc, 0, 0);
		for (int m = 0; m < 2; m++) begin
			wdt_mode <= m[0];
			wdt_to <= 1'b1;
			tick(1);
			wdt_to <= 1'b0;
			run_to(m ? 600 : 12);
			rng(ec, m ? PC : 0, m ? PC + 2 : 0);
		end
		fin(8'h20);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(1);
		chk({8'h00, cause}, 16'h0000);
		dbg_d <= 8'h01;
		dbg_wr <= 1'b1;
		tick(1);
		dbg_wr <= 1'b0;
		tick(3);
		chk({15'h0000, dbg_req}, 16'h0000);
		chk({15'h0000, sys_rst}, 16'h0001);
		run_to(600);
		fin(8'h80);
		for (int x = 0; x < 2; x++) begin
			xtal_en <= x[0];
			n = x ? SX : SC;
			stop_x <= 1'b1;
			tick(1);
			stop_x <= 1'b0;
			tick(2);
			chk({15'h0000, stop_m}, 16'h0001);
			wake <= 1'b1;
			tick(1);
			wake <= 1'b0;
			run_to(600);
			rng(cc, n, n + 4);
			rng(rc, 0, 0);
			rng(oc, 1, 1);
			fin(8'h10);
		end
		// debug line low while stopped: full reset with no cause bit
		xtal_en <= 1'b0;
		stop_x <= 1'b1;
		tick(1);
		stop_x <= 1'b0;
		tick(1);
		dpin_n <= 1'b0;
		tick(1);
		dpin_n <= 1'b1;
		run_to(600);
		rng(ec, hold_len(1'b0), hold_len(1'b0) + 2);
		fin(8'h00);
		complete_run;
	end
endmodule : tb_srsr_top

`default_nettype wire
